/* File: sewc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sewc_core_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sleep,
	input wire logic [7:0] i_irq,
	input wire logic i_wdog,
	input wire logic i_pin_rst,
	input wire logic i_brown,
	output logic o_sleep_exec,
	output logic [15:0] o_pc,
	output logic [7:0] o_irq_flags,
	output logic o_wdog_expire,
	output logic o_pin_rst_event,
	output logic o_brown_event,
	output logic [7:0] o_port_out,
	output logic [7:0] o_port_oe,
	output logic [15:0] o_held
);
	// standby instruction always sits at one fixed program address
	assign o_pc = 16'h0100;
	// commands become one-cycle pulses; port drive moves every cycle so
	// that a frozen copy cannot pass by luck
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_sleep_exec <= 1'b0;
			o_irq_flags <= 8'h00;
			o_wdog_expire <= 1'b0;
			o_pin_rst_event <= 1'b0;
			o_brown_event <= 1'b0;
			o_port_out <= 8'h5a;
			o_port_oe <= 8'h0f;
			o_held <= 16'h0000;
		end else begin
			o_sleep_exec <= i_sleep;
			o_irq_flags <= i_irq;
			o_wdog_expire <= i_wdog;
			o_pin_rst_event <= i_pin_rst;
			o_brown_event <= i_brown;
			o_port_out <= o_port_out + 8'h01;
			o_port_oe <= ~o_port_oe;
			if (o_sleep_exec) begin
				o_held <= {o_port_out, o_port_oe}; // drive at standby
			end
		end
	end
endmodule : sewc_core_model
`default_nettype wire

/* File: sewc_pkg.sv */
package sewc_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CORE_IRQ = 8'h08;
	localparam logic [7:0] ADDR_PEN1 = 8'h0C;
	localparam logic [7:0] ADDR_PEN2 = 8'h10;
	localparam logic [7:0] ADDR_PFL1 = 8'h14;
	localparam logic [7:0] ADDR_PFL2 = 8'h18;
	localparam logic [7:0] ADDR_IOCF = 8'h1C;
	localparam logic [7:0] ADDR_IOCN = 8'h20;
	localparam logic [7:0] ADDR_IOCP = 8'h24;
	localparam logic [7:0] ADDR_EVT = 8'h28;
	localparam logic [7:0] ADDR_MASK = 8'h2C;
	// control register fields
	localparam int CTRL_WDOG_EN = 0;
	localparam int CTRL_BROWN_EN = 1;
	localparam int CTRL_PIN_RST_EN = 2;
	localparam int CTRL_NOOST = 3;
	// watchdog enabled, every other control bit clear
	localparam logic [3:0] CTRL_RESET = 4'h1;
	// core interrupt control fields
	localparam int CI_GLOBAL_EN = 7;
	localparam int CI_PERIF_EN = 6;
	localparam int CI_EN_LSB = 3;
	localparam int CI_FLAG_LSB = 0;
	localparam int CI_SRC_N = 3;
	// event bits
	localparam int EV_ENTER = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_NOP = 2;
	localparam int EV_RESET = 3;
	localparam int EV_W = 4;
	// start-up delay in oscillator periods
	localparam int OSC_STARTUP_PERIODS = 1024;
	// shortest delay the start-up assertion can watch, longest the
	// 16-bit counter can hold
	localparam int OST_CHECK_CYCLES = 8;
	localparam int OST_MAX_CYCLES = 65535;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] IRQ_VECTOR = 16'h0004;
	localparam logic [15:0] PC_STEP = 16'h0001;
	typedef enum logic [1:0] {
		SEWC_RUN = 2'b00,
		SEWC_SLEEP = 2'b01,
		SEWC_OST = 2'b11
	} sewc_state_t;
endpackage : sewc_pkg

/* File: sewc_top.sv */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sewc_top #(
	parameter int OST_CYCLES = sewc_pkg::OSC_STARTUP_PERIODS,
	parameter int PORT_W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_sleep_exec,
	input wire logic [15:0] i_pc,
	input wire logic i_wdog_expire,
	input wire logic i_pin_rst_event,
	input wire logic i_brownout_event,
	input wire logic [7:0] i_ext_irq_flags,
	input wire logic [PORT_W-1:0] i_port_out,
	input wire logic [PORT_W-1:0] i_port_oe,
	output logic o_osc_en,
	output logic o_t1osc_en,
	output logic o_wdog_clear,
	output logic o_dev_reset,
	output logic o_resume,
	output logic o_vector,
	output logic [15:0] o_fetch_addr,
	output logic o_periph_clk_en,
	output logic [PORT_W-1:0] o_port_out,
	output logic [PORT_W-1:0] o_port_oe,
	output logic o_irq
);
	// the start-up counter is 16 bits wide and the delay assertion
	// watches eight cycles, so delays outside that span are refused
	initial begin
		if (OST_CYCLES < sewc_pkg::OST_CHECK_CYCLES)
			$error("sewc_top: start-up delay too short");
		if (OST_CYCLES > sewc_pkg::OST_MAX_CYCLES)
			$error("sewc_top: start-up delay too long");
		if (PORT_W < 1)
			$error("sewc_top: port width must be positive");
	end

	// whole block state in one record
	typedef struct packed {
		sewc_pkg::sewc_state_t st;
		logic [3:0] ctrl;
		logic pwrdn;
		logic tmo;
		logic [7:0] core_irq;
		logic [7:0] perif_en1;
		logic [7:0] perif_en2;
		logic [7:0] perif_fl1;
		logic [7:0] perif_fl2;
		logic [7:0] iocf;
		logic [7:0] iocn;
		logic [7:0] iocp;
		logic [4:0] evt;
		logic [4:0] mask;
		logic [15:0] cnt;
		logic [15:0] fetch;
		logic wdog_clr;
		logic rst;
		logic resume;
		logic vec;
		logic [PORT_W-1:0] pout;
		logic [PORT_W-1:0] poe;
		logic [31:0] rdata;
	} sewc_regs_t;

	sewc_regs_t r;
	sewc_regs_t next_r;

	// any source with both enable and flag set (peripheral sources also need the peripheral enable), or any pin-change flag alone; global enable ignored
	function automatic logic wake_pending(input sewc_regs_t s);
		logic core;
		logic peri;
		core = |(s.core_irq[sewc_pkg::CI_EN_LSB +: sewc_pkg::CI_SRC_N] &
			s.core_irq[sewc_pkg::CI_FLAG_LSB +: sewc_pkg::CI_SRC_N]);
		peri = s.core_irq[sewc_pkg::CI_PERIF_EN] &
			(|(s.perif_en1 & s.perif_fl1) | |(s.perif_en2 & s.perif_fl2));
		wake_pending = core | peri | |s.iocf;
	endfunction : wake_pending

	logic acc;
	logic wr;
	logic rd;
	logic irq_wake;
	logic wdog_en;
	logic wdog_wake;
	logic reset_wake;
	logic glob_en;
	logic [7:0] wdata;
	// bus phase decode
	assign acc = i_psel & i_penable;
	assign wr = acc & i_pwrite;
	assign rd = i_psel & ~i_penable & ~i_pwrite;
	assign wdata = i_pwdata[7:0];
	// combinational level only, so it works while the main clock is gated
	assign irq_wake = wake_pending(r);
	// wake and reset causes, each qualified by its own enable
	assign wdog_en = r.ctrl[sewc_pkg::CTRL_WDOG_EN];
	assign wdog_wake = i_wdog_expire & wdog_en;
	assign reset_wake =
		(i_pin_rst_event & r.ctrl[sewc_pkg::CTRL_PIN_RST_EN]) |
		(i_brownout_event & r.ctrl[sewc_pkg::CTRL_BROWN_EN]);
	assign glob_en = r.core_irq[sewc_pkg::CI_GLOBAL_EN];

	always_comb begin
		next_r = r;
		next_r.wdog_clr = 1'b0;
		next_r.rst = 1'b0;
		next_r.resume = 1'b0;
		next_r.vec = 1'b0;
		// hardware flag sets, applied before software writes
		next_r.core_irq[0] = r.core_irq[0] | i_ext_irq_flags[0];
		next_r.core_irq[1] = r.core_irq[1] | i_ext_irq_flags[1];
		next_r.perif_fl1 = r.perif_fl1 | {6'h0, i_ext_irq_flags[3:2]};
		// bus writes
		if (wr) begin
			unique case (i_paddr)
				sewc_pkg::ADDR_CTRL: next_r.ctrl = wdata[3:0];
				sewc_pkg::ADDR_CORE_IRQ: next_r.core_irq = wdata |
					{6'h0, i_ext_irq_flags[1:0]};
				sewc_pkg::ADDR_PEN1: next_r.perif_en1 = wdata;
				sewc_pkg::ADDR_PEN2: next_r.perif_en2 = wdata;
				sewc_pkg::ADDR_PFL1: next_r.perif_fl1 = wdata |
					{6'h0, i_ext_irq_flags[3:2]};
				sewc_pkg::ADDR_PFL2: next_r.perif_fl2 = wdata;
				sewc_pkg::ADDR_IOCF: next_r.iocf = r.iocf & wdata;
				sewc_pkg::ADDR_IOCN: next_r.iocn = wdata;
				sewc_pkg::ADDR_IOCP: next_r.iocp = wdata;
				sewc_pkg::ADDR_EVT: next_r.evt = r.evt & ~wdata[4:0];
				sewc_pkg::ADDR_MASK: next_r.mask = wdata[4:0];
				default: ;
			endcase
		end
		// pin-change flags from port inputs
		next_r.iocf = next_r.iocf | (i_ext_irq_flags[7:4] != 4'h0 ?
			(r.iocp | r.iocn) & {4'h0, i_ext_irq_flags[7:4]} : 8'h00);
		// standby sequencing
		unique case (r.st)
			sewc_pkg::SEWC_RUN: begin
				if (i_sleep_exec) begin
					next_r.fetch = 16'(i_pc + sewc_pkg::PC_STEP);
					if (irq_wake) begin
						// pending before: behaves as no-op
						next_r.evt[sewc_pkg::EV_NOP] = 1'b1;
					end else begin
						next_r.pwrdn = 1'b0;
						next_r.tmo = 1'b1;
						next_r.wdog_clr = wdog_en;
						next_r.pout = i_port_out;
						next_r.poe = i_port_oe;
						next_r.st = sewc_pkg::SEWC_SLEEP;
						next_r.evt[sewc_pkg::EV_ENTER] = 1'b1;
					end
				end
			end
			sewc_pkg::SEWC_SLEEP: begin
				// a reset request wins over any wake in the same cycle
				if (reset_wake) begin
					next_r.rst = 1'b1;
					next_r.pwrdn = 1'b1;
					next_r.st = sewc_pkg::SEWC_RUN;
					next_r.evt[sewc_pkg::EV_RESET] = 1'b1;
				end else if (wdog_wake | irq_wake) begin
					// interrupt arriving after entry wakes at once
					next_r.wdog_clr = 1'b1;
					if (wdog_wake) begin
						next_r.tmo = 1'b0;
						next_r.evt[sewc_pkg::EV_W] = 1'b1;
					end
					next_r.cnt = 16'(OST_CYCLES);
					next_r.evt[sewc_pkg::EV_WAKE] = 1'b1;
					next_r.st = r.ctrl[sewc_pkg::CTRL_NOOST] ?
						sewc_pkg::SEWC_RUN : sewc_pkg::SEWC_OST;
					if (r.ctrl[sewc_pkg::CTRL_NOOST]) begin
						next_r.resume = 1'b1;
						next_r.vec = glob_en & irq_wake;
					end
				end
			end
			sewc_pkg::SEWC_OST: begin
				// start-up wait before the core restarts
				next_r.cnt = 16'(r.cnt - sewc_pkg::CNT_ONE);
				if (r.cnt == sewc_pkg::CNT_ONE) begin
					next_r.resume = 1'b1;
					// vector only with global enable set
					next_r.vec = glob_en & irq_wake;
					next_r.st = sewc_pkg::SEWC_RUN;
				end
			end
			default: next_r.st = sewc_pkg::SEWC_RUN;
		endcase
		// read data captured in setup phase and held through the access
		// phase, so the master takes a settled word at its pready edge
		// instead of racing the register update on that edge
		next_r.rdata = acc ? r.rdata : 32'h0000_0000;
		if (rd) begin
			unique case (i_paddr)
				sewc_pkg::ADDR_CTRL: next_r.rdata = {28'h0, r.ctrl};
				sewc_pkg::ADDR_STATUS: next_r.rdata = {26'h0, r.st, 2'b00,
					r.tmo, r.pwrdn};
				sewc_pkg::ADDR_CORE_IRQ: next_r.rdata = {24'h0, r.core_irq};
				sewc_pkg::ADDR_PEN1: next_r.rdata = {24'h0, r.perif_en1};
				sewc_pkg::ADDR_PEN2: next_r.rdata = {24'h0, r.perif_en2};
				sewc_pkg::ADDR_PFL1: next_r.rdata = {24'h0, r.perif_fl1};
				sewc_pkg::ADDR_PFL2: next_r.rdata = {24'h0, r.perif_fl2};
				sewc_pkg::ADDR_IOCF: next_r.rdata = {24'h0, r.iocf};
				sewc_pkg::ADDR_IOCN: next_r.rdata = {24'h0, r.iocn};
				sewc_pkg::ADDR_IOCP: next_r.rdata = {24'h0, r.iocp};
				sewc_pkg::ADDR_EVT: next_r.rdata = {27'h0, r.evt};
				sewc_pkg::ADDR_MASK: next_r.rdata = {27'h0, r.mask};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// power-up values: power-down flag and timeout flag set
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= '0;
			r.st <= sewc_pkg::SEWC_RUN;
			r.pwrdn <= 1'b1;
			r.tmo <= 1'b1;
			r.ctrl <= sewc_pkg::CTRL_RESET;
			r.fetch <= 16'h0000;
		end else begin
			r <= next_r;
		end
	end

	// every access completes in one cycle and is never refused
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_prdata = r.rdata;

	// clock gating: only the low-power timer oscillator survives standby
	assign o_osc_en = (r.st != sewc_pkg::SEWC_SLEEP);
	assign o_t1osc_en = 1'b1;
	assign o_periph_clk_en = (r.st == sewc_pkg::SEWC_RUN);
	// core-facing pulses, one cycle each, straight from flip-flops; the fetch address is a mux of the vector and the stored fetch
	assign o_wdog_clear = r.wdog_clr;
	assign o_dev_reset = r.rst;
	assign o_resume = r.resume;
	assign o_vector = r.vec;
	assign o_fetch_addr = r.vec ? sewc_pkg::IRQ_VECTOR : r.fetch;
	// pins frozen while asleep or waiting on the oscillator
	assign o_port_out = (r.st == sewc_pkg::SEWC_RUN) ? i_port_out : r.pout;
	assign o_port_oe = (r.st == sewc_pkg::SEWC_RUN) ? i_port_oe : r.poe;
	// level interrupt from sticky events under the mask
	assign o_irq = |(r.evt & r.mask);

	// assertions
	sleep_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_RUN && i_sleep_exec && !irq_wake |=>
		!r.pwrdn && r.tmo && r.st == sewc_pkg::SEWC_SLEEP)
		else $error("standby entry flags wrong");
	nop_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_RUN && i_sleep_exec && irq_wake |=>
		$stable(r.pwrdn) && r.st == sewc_pkg::SEWC_RUN &&
		!o_wdog_clear)
		else $error("pending interrupt did not make standby a no-op");
	osc_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_SLEEP |-> !o_osc_en && o_t1osc_en)
		else $error("oscillator running in standby");
	reset_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_SLEEP && i_pin_rst_event &&
		r.ctrl[sewc_pkg::CTRL_PIN_RST_EN] |=>
		o_dev_reset && !o_resume)
		else $error("reset pin wake did not reset");
	wdt_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_SLEEP && wdog_wake && !reset_wake |=>
		!r.tmo && o_wdog_clear)
		else $error("watchdog wake flags wrong");
	prefetch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_RUN && i_sleep_exec |=>
		r.fetch == 16'($past(i_pc) + sewc_pkg::PC_STEP))
		else $error("prefetch address wrong");
	ost_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(r.st == sewc_pkg::SEWC_OST) |-> !o_resume [*8])
		else $error("resume before start-up delay");
	port_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_SLEEP |-> $stable(o_port_out) &&
		$stable(o_port_oe))
		else $error("ports changed in standby");
	vec_gie_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_vector |-> $past(glob_en) && o_resume)
		else $error("vectored without global enable");
	clk_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st != sewc_pkg::SEWC_RUN |-> !o_periph_clk_en)
		else $error("peripheral clock running in standby");
	reset_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_dev_reset |-> r.pwrdn && r.st == sewc_pkg::SEWC_RUN)
		else $error("reset wake left power-down flag clear");
	wake_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.st == sewc_pkg::SEWC_SLEEP && irq_wake && !reset_wake |=>
		o_wdog_clear && r.st != sewc_pkg::SEWC_SLEEP)
		else $error("interrupt wake did not clear watchdog");
	sleep_c: cover property (@(posedge i_clk) r.st == sewc_pkg::SEWC_SLEEP);
	vec_c: cover property (@(posedge i_clk) o_vector);
	rst_c: cover property (@(posedge i_clk) o_dev_reset);
	nop_c: cover property (@(posedge i_clk)
		r.st == sewc_pkg::SEWC_RUN && i_sleep_exec && irq_wake);
	ost_c: cover property (@(posedge i_clk)
		r.st == sewc_pkg::SEWC_OST && o_resume == 1'b0);
endmodule : sewc_top
`default_nettype wire

/* File: sewc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sewc_top_bench;
	logic clk, rst_n, psel, pen, pwr, c_sl, c_wd, c_mc, c_bo;
	logic [7:0] paddr, c_irq, fl, po, poe, opo, opoe;
	logic [31:0] pwdata, rd, prdata;
	logic pready, pslverr, sl, wd, mc, bo, osc, t1, wclr, drst, res, vec;
	logic pclk, irq;
	logic [15:0] pc, fa, held;
	int n_mismatch, cmp_count, n;
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	sewc_core_model cm (.i_clk(clk), .i_rst_n(rst_n), .i_sleep(c_sl),
		.i_irq(c_irq), .i_wdog(c_wd), .i_pin_rst(c_mc), .i_brown(c_bo),
		.o_sleep_exec(sl), .o_pc(pc), .o_irq_flags(fl),
		.o_wdog_expire(wd), .o_pin_rst_event(mc),
		.o_brown_event(bo), .o_port_out(po),
		.o_port_oe(poe), .o_held(held));
	// short start-up delay keeps the wake wait visible yet brief
	sewc_top #(.OST_CYCLES(8), .PORT_W(8)) dut (.i_clk(clk), .i_rst_n(rst_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_sleep_exec(sl), .i_pc(pc),
		.i_wdog_expire(wd), .i_pin_rst_event(mc),
		.i_brownout_event(bo),
		.i_ext_irq_flags(fl), .i_port_out(po), .i_port_oe(poe),
		.o_osc_en(osc), .o_t1osc_en(t1), .o_wdog_clear(wclr),
		.o_dev_reset(drst), .o_resume(res), .o_vector(vec),
		.o_fetch_addr(fa), .o_periph_clk_en(pclk), .o_port_out(opo),
		.o_port_oe(opoe), .o_irq(irq));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// apb transfer; request held until pready seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		if (k >= 20) n_mismatch++;
	endtask : apb
	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	// one-cycle command to the core model
	task cmd(input int w);
		@(posedge clk);
		c_sl <= (w == 0 || w == 5);
		c_irq <= (w == 1 || w == 5) ? 8'h01 : 8'h00;
		c_wd <= (w == 2);
		c_mc <= (w == 3);
		c_bo <= (w == 4);
		@(posedge clk);
		{c_sl, c_wd, c_mc, c_bo} <= 4'h0;
		c_irq <= 8'h00;
	endtask : cmd
	// 0 resume, 1 device reset, 2 watchdog clear; n counts edges
	task wait_for(input int w);
		logic s;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			s = (w == 0) ? res : (w == 1) ? drst : wclr;
		end while (s !== 1'b1 && n < 100);
		if (n >= 100) n_mismatch++;
	endtask : wait_for
	task conclude;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// a hang counts as a failure
	initial begin
		#40000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{rst_n, psel, pen, pwr, c_sl, c_wd, c_mc, c_bo} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		c_irq = 8'h00;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		chk({30'h0, pready, pslverr}, 32'h0000_0002);
		apb(0, 8'h3C, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1, sewc_pkg::ADDR_CORE_IRQ, 32'h0000_0008);
		apb(1, sewc_pkg::ADDR_MASK, 32'h0000_0002);
		cmd(0);
		wait_for(2);
		chk({29'h0, osc, t1, pclk}, 32'h0000_0002);
		chk({16'h0000, fa}, 32'h0000_0101);
		cyc(3);
		chk({16'h0000, opo, opoe}, {16'h0000, held});
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0012);
		cmd(1);
		wait_for(2);
		wait_for(0);
		chk({31'h0, n >= 8 && n <= 10}, 32'h0000_0001);
		chk({31'h0, vec}, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1, sewc_pkg::ADDR_EVT, 32'h0000_001F);
		cyc(1);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		$display("test interrupt wake done");
		cmd(0);
		cyc(3);
		chk({31'h0, osc}, 32'h0000_0001);
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		apb(0, sewc_pkg::ADDR_EVT, 32'h0000_0000);
		chk(rd & 32'h0000_0004, 32'h0000_0004);
		$display("test pending interrupt done");
		apb(1, sewc_pkg::ADDR_CTRL, 32'h0000_0009);
		apb(1, sewc_pkg::ADDR_CORE_IRQ, 32'h0000_0080);
		cmd(0);
		cmd(1);
		cyc(4);
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0012);
		cmd(2);
		wait_for(0);
		chk({31'h0, vec}, 32'h0000_0000);
		apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("test watchdog wake done");
		apb(1, sewc_pkg::ADDR_CORE_IRQ, 32'h0000_0088);
		cmd(0);
		wait_for(2);
		cmd(1);
		wait_for(0);
		chk({15'h0, vec, fa}, {15'h0, 1'b1, 16'h0004});
		$display("test vectored wake done");
		apb(1, sewc_pkg::ADDR_CORE_IRQ, 32'h0000_0008);
		apb(1, sewc_pkg::ADDR_EVT, 32'h0000_001F);
		cmd(5);
		wait_for(0);
		apb(0, sewc_pkg::ADDR_EVT, 32'h0000_0000);
		chk(rd & 32'h0000_0003, 32'h0000_0003);
		$display("test late interrupt done");
		apb(1, sewc_pkg::ADDR_CORE_IRQ, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			apb(1, sewc_pkg::ADDR_CTRL, (k == 0) ? 32'h0000_0005 : 32'h0000_0003);
			cmd(0);
			wait_for(2);
			cmd(3 + k);
			wait_for(1);
			apb(0, sewc_pkg::ADDR_STATUS, 32'h0000_0000);
			chk(rd & 32'h0000_0031, 32'h0000_0001);
		end
		$display("test reset wake done");
		conclude();
	end
endmodule : sewc_top_bench
`default_nettype wire
